// ### src/rcv_pkg.sv
// Constants, register map and reset values of the reset and configuration block.
// Assumes one 125 MHz clock (the E clock of this build) and an 8-bit register port.
// What this block does
// - Clock-watch enable is read/write any time, enables clock-fail reset, cleared by reset.
// - Clock-watch force set keeps the monitor on until next reset; else follows enable.
// - With force set, a slow or stopped clock causes a clock-failure reset.
// - Watchdog clock is E divided by 2^15, then scaled by the rate select.
// - Rate select scales by 1, 4, 16, 64; reset selects the shortest.
// - Protected option bits take one write in first 64 cycles; special modes any time.
// - Config reads return the value latched at last reset or since written in special; bits 6 and 5 read one.
// - Special variant makes config writable; otherwise changes only after next reset.
// - ROM high-map places ROM at 8000-FFFF; low map only in expanded mode.
// - Pull-up assignment enable activates the pull-up register; clear turns pull-ups off.
// - Security-off set disables EEPROM and RAM protection; clear enables it.
// - Watchdog-off set disables the watchdog; clear lets a timeout force reset.
// - ROM-present and EEPROM-present bits include those memories in the map.
// - Vector by cause: FFFE pin/power, FFFC clock fail, FFFA watchdog; BFFx in special.
// - CPU fetches the restart vector in three cycles, then runs.
// - Reset sets both interrupt masks and the stop-disable bit.
// - Remap register loads 00: RAM at 0080-047F, registers 0000-007F, EEPROM 0D80.
// - Expanded reset dedicates ports B, C, F to the bus; single chip makes inputs.
// - Timer resets count 0000, compares FFFF, clears masks, flags, edges; selects compare 5.
// - Reset clears tick flag and rate, masks it, disables pulse accumulator.
// - Serial units load baud 0004, mask interrupts, disable all, 8-bit, transmit flags set.
// - Reset loads priority select 00110 and level-sensitive external interrupt.
// - Reset loads boot, special, mode-A bits from mode pins; sets delay; clears watch bits.
// - Pin or power reset beats clock-fail reset, which beats watchdog reset.
package rcv_pkg;
  localparam logic [7:0] ADDR_OPTION = 8'h39;
  localparam logic [7:0] ADDR_WDSVC = 8'h3a;
  localparam logic [7:0] ADDR_HPRIO = 8'h3c;
  localparam logic [7:0] ADDR_CONFIG = 8'h3f;
  localparam logic [7:0] WD_ARM_KEY = 8'h55;
  localparam logic [7:0] WD_CLR_KEY = 8'hAA;
  // Option field positions
  localparam int OPT_ADPU = 7;
  localparam int OPT_CSEL = 6;
  localparam int OPT_IRQE = 5;
  localparam int OPT_DLY = 4;
  localparam int OPT_CME = 3;
  localparam int OPT_CLOCK_WATCH_FORCE = 2;
  localparam logic [7:0] OPTION_RST = 8'h10;
  localparam logic [7:0] OPT_PROT_MASK = 8'h37;
  localparam logic [7:0] OPT_FREE_MASK = 8'hC8;
  // Config field positions
  localparam int CFG_ROM_HIGH_MAP = 7;
  localparam int CFG_PULLUP = 4;
  localparam int CFG_SECOFF = 3;
  localparam int CFG_WDOFF = 2;
  localparam int CFG_ROM_PRESENT = 1;
  localparam int CFG_EEPROM_PRESENT = 0;
  localparam logic [7:0] CFG_ONES_MASK = 8'h60;
  localparam logic [4:0] PSEL_RST = 5'h06;
  // Vectors and map
  localparam logic [15:0] VEC_PIN = 16'hFFFE;
  localparam logic [15:0] VEC_CLKMON = 16'hFFFC;
  localparam logic [15:0] VEC_WDT = 16'hFFFA;
  localparam logic [15:0] VEC_SPECIAL_CLR = 16'hBFFF;
  localparam logic [15:0] ROM_HIGH_BASE = 16'h8000;
  localparam logic [15:0] ROM_LOW_BASE = 16'h0000;
  localparam logic [15:0] RAM_BASE_RST = 16'h0080;
  localparam logic [15:0] REG_BASE_RST = 16'h0000;
  localparam logic [15:0] EE_BASE_RST = 16'h0D80;
  localparam logic [7:0] REMAP_RST = 8'h00;
  // Peripheral reset values
  localparam logic [15:0] TMR_CNT_RST = 16'h0000;
  localparam logic [15:0] TMR_OC_RST = 16'hFFFF;
  localparam logic [15:0] SCI_BAUD_RST = 16'h0004;
  localparam logic [2:0] CCR_MASK_RST = 3'b111;
  // Cycle counts
  localparam logic [2:0] HOLD_CYC = 3'd4;
  localparam logic [2:0] FETCH_CYC = 3'd3;
  localparam logic [6:0] PROT_WIN_CYC = 7'd64;
  localparam int WD_PRESC_BITS = 15;
  // Reset causes, lower code wins
  localparam logic [1:0] CAUSE_PIN = 2'd0;
  localparam logic [1:0] CAUSE_CLKMON = 2'd1;
  localparam logic [1:0] CAUSE_WDT = 2'd2;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_FETCH = 2'b01,
    ST_RUN = 2'b10,
    ST_HOLD = 2'b11
  } rcv_state_e;
endpackage

// ### src/rcv_reset_config.sv
// Reset sequencer, option, configuration and priority registers, reset defaults.
// Assumes a synchronous clock-fail level from the analog RC detector and EEPROM cell values.
`timescale 1ns/10ps
module rcv_reset_config #(
  parameter int WD_PRESC = rcv_pkg::WD_PRESC_BITS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic ext_rst_i,
  input wire logic clk_fail_i,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic [7:0] nv_cfg_i,
  input wire logic cpu_i_mask_i,
  output logic cpu_rst_o,
  output logic cpu_fetch_o,
  output logic [15:0] vec_addr_o,
  output logic [1:0] reset_cause_o,
  output logic [2:0] ccr_mask_init_o,
  output logic periph_rst_o,
  output logic [15:0] rom_base_o,
  output logic rom_present_o,
  output logic eeprom_present_o,
  output logic [15:0] eeprom_base_o,
  output logic [15:0] ram_base_o,
  output logic [15:0] reg_base_o,
  output logic [7:0] ram_remap_o,
  output logic pullup_enable_o,
  output logic security_on_o,
  output logic watchdog_en_o,
  output logic boot_rom_read_o,
  output logic bus_ports_o,
  output logic irq_edge_o,
  output logic osc_startup_delay_o,
  output logic clock_watch_active_o,
  output logic adc_power_o,
  output logic [4:0] psel_o,
  output logic [15:0] timer_cnt_init_o,
  output logic [15:0] timer_oc_init_o,
  output logic [15:0] sci_baud_init_o
);
  import rcv_pkg::*;

  rcv_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [1:0] cause_q, cause_d;
  logic [15:0] vec_q, vec_d;
  logic cpu_rst_q, cpu_rst_d;
  logic fetch_q, fetch_d;
  logic periph_rst_q, periph_rst_d;

  logic [7:0] option_q, option_d;
  logic [7:0] cfg_q, cfg_d;
  logic boot_q, boot_d;
  logic special_variant_q, special_variant_d;
  logic mda_q, mda_d;
  logic [4:0] psel_q, psel_d;
  logic [6:0] win_q, win_d;
  logic prot_done_q, prot_done_d;
  logic [7:0] rdata_q, rdata_d;
  logic [15:0] rom_base_q, rom_base_d;
  logic rom_on_q, rom_on_d;
  logic ee_on_q, ee_on_d;
  logic pullup_q, pullup_d;
  logic sec_on_q, sec_on_d;
  logic wd_en_q, wd_en_d;
  logic bus_ports_q, bus_ports_d;
  logic watch_q, watch_d;

  logic wd_timeout;
  logic mon_en;
  logic pin_req, mon_req, any_req;
  logic [1:0] req_cause;
  logic special_pins;
  logic soft_init;
  logic wd_run;

  // Monitor can be forced on; force is sticky until reset
  assign mon_en = option_q[OPT_CME] | option_q[OPT_CLOCK_WATCH_FORCE];
  assign mon_req = clk_fail_i & mon_en;
  assign pin_req = ext_rst_i;
  assign any_req = pin_req | mon_req | wd_timeout;
  assign special_pins = ~mode_pin_b_i;
  assign soft_init = (state_q == ST_HOLD);
  assign wd_run = ~cfg_q[CFG_WDOFF] & (state_q == ST_RUN);

  always_comb begin
    if (pin_req) begin
      req_cause = CAUSE_PIN;
    end else if (mon_req) begin
      req_cause = CAUSE_CLKMON;
    end else begin
      req_cause = CAUSE_WDT;
    end
  end

  function automatic logic [15:0] rst_vector(input logic [1:0] cause, input logic special);
    logic [15:0] v;
    v = VEC_PIN;
    if (cause == CAUSE_CLKMON) begin
      v = VEC_CLKMON;
    end else if (cause == CAUSE_WDT) begin
      v = VEC_WDT;
    end
    if (special) begin
      v = v & VEC_SPECIAL_CLR;
    end
    rst_vector = v;
  endfunction

  // Sequencer: hold internal reset, load straps and latches, fetch, run
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    vec_d = vec_q;
    cpu_rst_d = 1'b1;
    fetch_d = 1'b0;
    periph_rst_d = 1'b1;
    case (state_q)
      ST_LOAD: begin
        vec_d = rst_vector(cause_q, special_pins);
        state_d = ST_FETCH;
        cnt_d = '0;
        cpu_rst_d = 1'b0;
        fetch_d = 1'b1;
        periph_rst_d = 1'b0;
      end
      ST_FETCH: begin
        cpu_rst_d = 1'b0;
        periph_rst_d = 1'b0;
        fetch_d = 1'b1;
        if (cnt_q == FETCH_CYC - 3'd1) begin
          state_d = ST_RUN;
          fetch_d = 1'b0;
        end else begin
          cnt_d = cnt_q + 3'd1;
        end
        if (any_req) begin
          state_d = ST_HOLD;
          cause_d = req_cause;
          cnt_d = '0;
          cpu_rst_d = 1'b1;
          fetch_d = 1'b0;
          periph_rst_d = 1'b1;
        end
      end
      ST_RUN: begin
        cpu_rst_d = 1'b0;
        periph_rst_d = 1'b0;
        if (any_req) begin
          state_d = ST_HOLD;
          cause_d = req_cause;
          cnt_d = '0;
          cpu_rst_d = 1'b1;
          periph_rst_d = 1'b1;
        end
      end
      ST_HOLD: begin
        if (pin_req | mon_req) begin
          if (req_cause < cause_q) begin
            cause_d = req_cause;
          end
        end
        if (cnt_q == HOLD_CYC - 3'd1) begin
          state_d = ST_LOAD;
        end else begin
          cnt_d = cnt_q + 3'd1;
        end
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_q <= ST_LOAD;
      cnt_q <= '0;
      cause_q <= CAUSE_PIN;
      vec_q <= VEC_PIN;
      cpu_rst_q <= 1'b1;
      fetch_q <= 1'b0;
      periph_rst_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
      vec_q <= vec_d;
      cpu_rst_q <= cpu_rst_d;
      fetch_q <= fetch_d;
      periph_rst_q <= periph_rst_d;
    end
  end

  // Registers; internal reset reinitialises them like a power-on
  always_comb begin
    option_d = option_q;
    cfg_d = cfg_q;
    boot_d = boot_q;
    special_variant_d = special_variant_q;
    mda_d = mda_q;
    psel_d = psel_q;
    win_d = win_q;
    prot_done_d = prot_done_q;
    rdata_d = '0;
    if (soft_init) begin
      option_d = OPTION_RST;
      psel_d = PSEL_RST;
      win_d = '0;
      prot_done_d = 1'b0;
    end else if (state_q == ST_LOAD) begin
      cfg_d = nv_cfg_i;
      special_variant_d = ~mode_pin_b_i;
      mda_d = mode_pin_a_i;
      boot_d = ~mode_pin_b_i & ~mode_pin_a_i;
      win_d = '0;
      prot_done_d = 1'b0;
    end else begin
      if (win_q < PROT_WIN_CYC) begin
        win_d = win_q + 7'd1;
      end
      if (wr_i) begin
        if (addr_i == ADDR_OPTION) begin
          option_d = (option_q & ~OPT_FREE_MASK) | (wdata_i & OPT_FREE_MASK);
          if (special_variant_q || (win_q < PROT_WIN_CYC && !prot_done_q)) begin
            option_d = (option_d & ~OPT_PROT_MASK) | (wdata_i & OPT_PROT_MASK);
            prot_done_d = ~special_variant_q;
          end
          // Force cannot be withdrawn by software in any mode
          option_d[OPT_CLOCK_WATCH_FORCE] = option_d[OPT_CLOCK_WATCH_FORCE] | option_q[OPT_CLOCK_WATCH_FORCE];
        end else if (addr_i == ADDR_CONFIG) begin
          if (special_variant_q) begin
            cfg_d = wdata_i;
          end
        end else if (addr_i == ADDR_HPRIO) begin
          if (special_variant_q) begin
            boot_d = wdata_i[7];
            special_variant_d = wdata_i[6];
            mda_d = wdata_i[5];
          end
          if (cpu_i_mask_i) begin
            psel_d = wdata_i[4:0];
          end
        end
      end
    end
    if (rd_i) begin
      if (addr_i == ADDR_OPTION) begin
        rdata_d = option_q;
      end else if (addr_i == ADDR_CONFIG) begin
        rdata_d = cfg_q | CFG_ONES_MASK;
      end else if (addr_i == ADDR_HPRIO) begin
        rdata_d = {boot_q, special_variant_q, mda_q, psel_q};
      end
    end
  end

  // Decoded map and port controls, registered so each output leaves a flip-flop
  always_comb begin
    rom_base_d = (cfg_q[CFG_ROM_HIGH_MAP] || !mda_q) ? ROM_HIGH_BASE : ROM_LOW_BASE;
    rom_on_d = cfg_q[CFG_ROM_PRESENT];
    ee_on_d = cfg_q[CFG_EEPROM_PRESENT];
    pullup_d = cfg_q[CFG_PULLUP];
    sec_on_d = ~cfg_q[CFG_SECOFF];
    wd_en_d = ~cfg_q[CFG_WDOFF];
    bus_ports_d = mda_q;
    watch_d = mon_en;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      option_q <= OPTION_RST;
      cfg_q <= '0;
      boot_q <= 1'b0;
      special_variant_q <= 1'b0;
      mda_q <= 1'b0;
      psel_q <= PSEL_RST;
      win_q <= '0;
      prot_done_q <= 1'b0;
      rdata_q <= '0;
      rom_base_q <= ROM_HIGH_BASE;
      rom_on_q <= 1'b0;
      ee_on_q <= 1'b0;
      pullup_q <= 1'b0;
      sec_on_q <= 1'b1;
      wd_en_q <= 1'b0;
      bus_ports_q <= 1'b0;
      watch_q <= 1'b0;
    end else begin
      option_q <= option_d;
      cfg_q <= cfg_d;
      boot_q <= boot_d;
      special_variant_q <= special_variant_d;
      mda_q <= mda_d;
      psel_q <= psel_d;
      win_q <= win_d;
      prot_done_q <= prot_done_d;
      rdata_q <= rdata_d;
      rom_base_q <= rom_base_d;
      rom_on_q <= rom_on_d;
      ee_on_q <= ee_on_d;
      pullup_q <= pullup_d;
      sec_on_q <= sec_on_d;
      wd_en_q <= wd_en_d;
      bus_ports_q <= bus_ports_d;
      watch_q <= watch_d;
    end
  end

  // Fixed reset images handed to the CPU and peripherals
  logic [2:0] ccr_init_q;
  logic [15:0] tmr_cnt_q;
  logic [15:0] tmr_oc_q;
  logic [15:0] sci_baud_q;
  logic [15:0] ram_base_q;
  logic [15:0] reg_base_q;
  logic [15:0] ee_base_q;
  logic [7:0] remap_q;
  always_ff @(posedge clk_i) begin
    ccr_init_q <= CCR_MASK_RST;
    tmr_cnt_q <= TMR_CNT_RST;
    tmr_oc_q <= TMR_OC_RST;
    sci_baud_q <= SCI_BAUD_RST;
    ram_base_q <= RAM_BASE_RST;
    reg_base_q <= REG_BASE_RST;
    ee_base_q <= EE_BASE_RST;
    remap_q <= REMAP_RST;
  end

  // Held off during reset so a stale count cannot fire straight after it
  rcv_watchdog #(
    .PRESC_BITS(WD_PRESC)
  ) u_wdt (
    .clk_i(clk_i),
    .rstn_i(rstn_i & ~soft_init),
    .enable_i(wd_run),
    .rate_sel_i(option_q[1:0]),
    .svc_wr_i(wr_i && addr_i == ADDR_WDSVC),
    .svc_data_i(wdata_i),
    .timeout_o(wd_timeout)
  );

  assign rdata_o = rdata_q;
  assign cpu_rst_o = cpu_rst_q;
  assign cpu_fetch_o = fetch_q;
  assign vec_addr_o = vec_q;
  assign reset_cause_o = cause_q;
  assign ccr_mask_init_o = ccr_init_q;
  // Peripheral reset clears flags, masks, tick rate, pulse accumulator, serial enables
  assign periph_rst_o = periph_rst_q;
  assign rom_base_o = rom_base_q;
  assign rom_present_o = rom_on_q;
  assign eeprom_present_o = ee_on_q;
  assign eeprom_base_o = ee_base_q;
  assign ram_base_o = ram_base_q;
  assign reg_base_o = reg_base_q;
  assign ram_remap_o = remap_q;
  assign pullup_enable_o = pullup_q;
  assign security_on_o = sec_on_q;
  assign watchdog_en_o = wd_en_q;
  assign boot_rom_read_o = boot_q;
  assign bus_ports_o = bus_ports_q;
  assign irq_edge_o = option_q[OPT_IRQE];
  assign osc_startup_delay_o = option_q[OPT_DLY];
  assign clock_watch_active_o = watch_q;
  assign adc_power_o = option_q[OPT_ADPU];
  assign psel_o = psel_q;
  assign timer_cnt_init_o = tmr_cnt_q;
  assign timer_oc_init_o = tmr_oc_q;
  assign sci_baud_init_o = sci_baud_q;
endmodule

// ### src/rcv_watchdog.sv
// Liveness watchdog: prescaled free-running counter with arm/clear service keys.
// Assumes the service strobe is a one-cycle write to the service address.
`timescale 1ns/10ps
module rcv_watchdog #(
  parameter int PRESC_BITS = rcv_pkg::WD_PRESC_BITS
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic enable_i,
  input wire logic [1:0] rate_sel_i,
  input wire logic svc_wr_i,
  input wire logic [7:0] svc_data_i,
  output logic timeout_o
);
  import rcv_pkg::*;
  localparam int W = PRESC_BITS + 6;
  logic [W-1:0] cnt_q, cnt_d;
  logic armed_q, armed_d;
  logic timeout_q, timeout_d;

  // Terminal count: 2^PRESC_BITS times 1, 4, 16 or 64
  function automatic logic [W-1:0] wd_limit(input logic [1:0] sel);
    logic [W-1:0] ones;
    ones = '1;
    wd_limit = ones >> (3'd6 - {sel, 1'b0});
  endfunction

  always_comb begin
    cnt_d = cnt_q;
    armed_d = armed_q;
    timeout_d = 1'b0;
    if (!enable_i) begin
      cnt_d = '0;
      armed_d = 1'b0;
    end else begin
      if (cnt_q >= wd_limit(rate_sel_i)) begin
        timeout_d = 1'b1;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
      if (svc_wr_i) begin
        if (svc_data_i == WD_ARM_KEY) begin
          armed_d = 1'b1;
        end else if (svc_data_i == WD_CLR_KEY && armed_q) begin
          armed_d = 1'b0;
          cnt_d = '0;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
      timeout_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      armed_q <= armed_d;
      timeout_q <= timeout_d;
    end
  end

  assign timeout_o = timeout_q;
endmodule

// ### tb/rcv_far_model.sv
// Far side: CPU interrupt-mask image and the EEPROM configuration cells.
// Assumes the bench programs the cells only while the CPU is held in reset.
`timescale 1ns/10ps
module rcv_far_model (
  input wire logic clk_i,
  input wire logic cpu_rst_i,
  input wire logic [2:0] ccr_mask_i,
  input wire logic prog_i,
  input wire logic [7:0] prog_data_i,
  output logic [7:0] nv_cfg_o,
  output logic i_mask_o
);
  logic [7:0] cells_q = 8'h1E;
  logic mask_q = 1'b1;
  // Cells change only by programming; the block sees them at its next load
  always_ff @(posedge clk_i) begin
    if (prog_i) begin
      cells_q <= prog_data_i;
    end
    if (cpu_rst_i === 1'b1) begin
      mask_q <= ccr_mask_i[0];
    end
  end
  assign nv_cfg_o = cells_q;
  assign i_mask_o = mask_q;
endmodule

// ### tb/rcv_reset_config_props.sv
// Checker of the reset and configuration block, watching its ports only.
// Assumes mode pins and EEPROM cells stay put while the CPU runs.
`timescale 1ns/10ps
module rcv_reset_config_props
  import rcv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic ext_rst_i,
  input wire logic clk_fail_i,
  input wire logic mode_pin_a_i,
  input wire logic mode_pin_b_i,
  input wire logic [7:0] nv_cfg_i,
  input wire logic cpu_rst_o,
  input wire logic cpu_fetch_o,
  input wire logic periph_rst_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic [1:0] reset_cause_o,
  input wire logic [2:0] ccr_mask_init_o,
  input wire logic rom_present_o,
  input wire logic eeprom_present_o,
  input wire logic [15:0] eeprom_base_o,
  input wire logic [15:0] ram_base_o,
  input wire logic [15:0] reg_base_o,
  input wire logic [7:0] ram_remap_o,
  input wire logic pullup_enable_o,
  input wire logic security_on_o,
  input wire logic watchdog_en_o,
  input wire logic boot_rom_read_o,
  input wire logic bus_ports_o,
  input wire logic irq_edge_o,
  input wire logic osc_startup_delay_o,
  input wire logic clock_watch_active_o,
  input wire logic adc_power_o,
  input wire logic [4:0] psel_o,
  input wire logic [15:0] timer_cnt_init_o,
  input wire logic [15:0] timer_oc_init_o,
  input wire logic [15:0] sci_baud_init_o
);
  logic [15:0] vec_exp;
  logic idle;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Live pins mirror the mode latched at load
  always_comb begin
    vec_exp = (reset_cause_o == CAUSE_PIN) ? VEC_PIN : (reset_cause_o == CAUSE_CLKMON) ? VEC_CLKMON : VEC_WDT;
    if (!mode_pin_b_i) begin
      vec_exp = vec_exp & VEC_SPECIAL_CLR;
    end
  end
  assign idle = !cpu_rst_o && !cpu_fetch_o;
  chk_fetch_len: assert property ($rose(cpu_fetch_o) |-> cpu_fetch_o[*3] ##1 !cpu_fetch_o)
    else $error("vector fetch not three cycles");
  chk_hold_len: assert property ($rose(cpu_rst_o) |-> cpu_rst_o[*5] ##1 (!cpu_rst_o && cpu_fetch_o))
    else $error("internal reset sequence length wrong");
  chk_vec_sel: assert property (cpu_fetch_o |-> vec_addr_o == vec_exp)
    else $error("reset vector address wrong");
  chk_pin_first: assert property (ext_rst_i && idle |=> cpu_rst_o && reset_cause_o == CAUSE_PIN)
    else $error("pin reset not taken first");
  chk_clk_fail: assert property (clk_fail_i && clock_watch_active_o && !ext_rst_i && idle
    |=> cpu_rst_o && reset_cause_o == CAUSE_CLKMON)
    else $error("clock failure reset missing");
  chk_cfg_image: assert property ($fell(cpu_rst_o) |-> ##2 (pullup_enable_o == nv_cfg_i[4]
    && security_on_o == !nv_cfg_i[3] && watchdog_en_o == !nv_cfg_i[2]
    && rom_present_o == nv_cfg_i[1] && eeprom_present_o == nv_cfg_i[0]))
    else $error("config image not taken from cells");
  chk_reset_image: assert property ($fell(cpu_rst_o) |-> ##2 (!irq_edge_o && osc_startup_delay_o
    && !clock_watch_active_o && !adc_power_o && psel_o == PSEL_RST && bus_ports_o == mode_pin_a_i
    && boot_rom_read_o == (!mode_pin_a_i && !mode_pin_b_i)))
    else $error("option or priority reset state wrong");
  chk_cfg_ones: assert property (rd_i && addr_i == ADDR_CONFIG |=> rdata_o[6:5] == 2'b11)
    else $error("unused config bits not one");
  chk_map_consts: assert property (ccr_mask_init_o == CCR_MASK_RST && ram_base_o == RAM_BASE_RST
    && reg_base_o == REG_BASE_RST && ram_remap_o == REMAP_RST && eeprom_base_o == EE_BASE_RST)
    else $error("cpu or map reset image wrong");
  chk_periph_init: assert property (timer_cnt_init_o == TMR_CNT_RST && timer_oc_init_o == TMR_OC_RST
    && sci_baud_init_o == SCI_BAUD_RST && periph_rst_o == cpu_rst_o)
    else $error("peripheral reset image wrong");
  cov_wdt: cover property ($rose(cpu_rst_o) ##1 reset_cause_o == CAUSE_WDT);
  cov_clk: cover property ($rose(cpu_rst_o) ##1 reset_cause_o == CAUSE_CLKMON);
  cov_special: cover property (cpu_fetch_o && !mode_pin_b_i);
endmodule

bind rcv_reset_config rcv_reset_config_props i_props (.clk_i, .rstn_i, .addr_i, .rd_i, .rdata_o, .ext_rst_i,
  .clk_fail_i, .mode_pin_a_i, .mode_pin_b_i, .nv_cfg_i, .cpu_rst_o, .cpu_fetch_o, .vec_addr_o, .reset_cause_o,
  .ccr_mask_init_o, .rom_present_o, .eeprom_present_o, .eeprom_base_o, .ram_base_o, .reg_base_o, .ram_remap_o,
  .pullup_enable_o, .security_on_o, .watchdog_en_o, .boot_rom_read_o, .bus_ports_o, .irq_edge_o,
  .osc_startup_delay_o, .clock_watch_active_o, .adc_power_o, .psel_o, .timer_cnt_init_o, .timer_oc_init_o,
  .sci_baud_init_o, .periph_rst_o);

// ### tb/rcv_reset_config_tb.sv
// Testbench of the reset and configuration block with the far-side model.
// Assumes a 125 MHz clock and a shortened watchdog prescaler.
`timescale 1ns/10ps
module rcv_reset_config_tb;
  import rcv_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic ext_rst_i = 1'b0;
  logic clk_fail_i = 1'b0;
  logic mode_pin_a_i = 1'b1;
  logic mode_pin_b_i = 1'b1;
  logic prog_i = 1'b0;
  logic [7:0] prog_data_i = 8'h00;
  logic [7:0] rdata_o, nv_cfg, d;
  logic i_mask, cpu_rst_o, cpu_fetch_o, pullup_enable_o, security_on_o, watchdog_en_o;
  logic boot_rom_read_o, bus_ports_o, clock_watch_active_o;
  logic [15:0] vec_addr_o, rom_base_o;
  logic [1:0] reset_cause_o;
  logic [2:0] ccr_mask_init_o;
  int miscompares = 0;
  int total_checks = 0;
  always #4 clk_i = ~clk_i;
  // Short prescaler for short watchdog timeouts
  rcv_reset_config #(.WD_PRESC(4)) i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_rst_i(ext_rst_i), .clk_fail_i(clk_fail_i),
    .mode_pin_a_i(mode_pin_a_i), .mode_pin_b_i(mode_pin_b_i), .nv_cfg_i(nv_cfg), .cpu_i_mask_i(i_mask),
    .cpu_rst_o(cpu_rst_o), .cpu_fetch_o(cpu_fetch_o), .vec_addr_o(vec_addr_o), .reset_cause_o(reset_cause_o),
    .ccr_mask_init_o(ccr_mask_init_o), .periph_rst_o(), .rom_base_o(rom_base_o), .rom_present_o(),
    .eeprom_present_o(), .eeprom_base_o(), .ram_base_o(), .reg_base_o(), .ram_remap_o(),
    .pullup_enable_o(pullup_enable_o), .security_on_o(security_on_o), .watchdog_en_o(watchdog_en_o),
    .boot_rom_read_o(boot_rom_read_o), .bus_ports_o(bus_ports_o), .irq_edge_o(), .osc_startup_delay_o(),
    .clock_watch_active_o(clock_watch_active_o), .adc_power_o(), .psel_o(), .timer_cnt_init_o(),
    .timer_oc_init_o(), .sci_baud_init_o());
  rcv_far_model i_far (.clk_i(clk_i), .cpu_rst_i(cpu_rst_o), .ccr_mask_i(ccr_mask_init_o), .prog_i(prog_i),
    .prog_data_i(prog_data_i), .nv_cfg_o(nv_cfg), .i_mask_o(i_mask));
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int n, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h to %h", $time, n, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic wait_rst(output int n);
    for (n = 0; n < 3000; n++) begin
      @(posedge clk_i);
      #1;
      if (cpu_rst_o === 1'b1) return;
    end
    miscompares++;
    end_sim();
  endtask
  task automatic wait_fetch();
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_i);
      #1;
      if (cpu_fetch_o === 1'b1) return;
    end
    miscompares++;
    end_sim();
  endtask
  // Ends at the edge that enters the run state, inside the option write window
  task automatic boot(input logic pa, input logic pb, input logic [7:0] cfg);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    mode_pin_a_i <= pa;
    mode_pin_b_i <= pb;
    prog_i <= 1'b1;
    prog_data_i <= cfg;
    @(posedge clk_i);
    prog_i <= 1'b0;
    repeat (19) @(posedge clk_i);
    rstn_i <= 1'b1;
    wait_fetch();
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pulse(input logic pin, input logic fail);
    @(posedge clk_i);
    ext_rst_i <= pin;
    clk_fail_i <= fail;
    @(posedge clk_i);
    ext_rst_i <= 1'b0;
    clk_fail_i <= 1'b0;
    wait_fetch();
  endtask
  task automatic t_normal();
    boot(1'b1, 1'b1, 8'h1E);
    rd(ADDR_CONFIG, d);
    chk(16'(d), 16'h007E);
    chk(rom_base_o, ROM_LOW_BASE);
    chk(16'(bus_ports_o), 16'h0001);
    rd(ADDR_OPTION, d);
    chk(16'(d), 16'h0010);
    wr(ADDR_OPTION, 8'hFF);
    rd(ADDR_OPTION, d);
    chk(16'(d), 16'h00FF);
    wr(ADDR_OPTION, 8'h00);
    rd(ADDR_OPTION, d);
    chk(16'(d), 16'h0037);
    chk(16'(clock_watch_active_o), 16'h0001);
    wr(ADDR_CONFIG, 8'h00);
    rd(ADDR_CONFIG, d);
    chk(16'(d), 16'h007E);
    pulse(1'b0, 1'b1);
    chk(16'(reset_cause_o), 16'(CAUSE_CLKMON));
    chk(vec_addr_o, VEC_CLKMON);
    repeat (3) @(posedge clk_i);
    rd(ADDR_OPTION, d);
    chk(16'(d), 16'h0010);
    wr(ADDR_OPTION, 8'h08);
    repeat (2) @(posedge clk_i);
    chk(16'(clock_watch_active_o), 16'h0001);
    pulse(1'b1, 1'b1);
    chk(16'(reset_cause_o), 16'(CAUSE_PIN));
    chk(vec_addr_o, VEC_PIN);
    repeat (70) @(posedge clk_i);
    wr(ADDR_OPTION, 8'h01);
    rd(ADDR_OPTION, d);
    chk(16'(d), 16'h0010);
    $display("t_normal done");
  endtask
  task automatic t_special();
    boot(1'b0, 1'b0, 8'h1E);
    chk(vec_addr_o, 16'hBFFE);
    chk(16'(boot_rom_read_o), 16'h0001);
    wr(ADDR_CONFIG, 8'h9C);
    rd(ADDR_CONFIG, d);
    chk(16'(d), 16'h00FC);
    chk({13'h0000, pullup_enable_o, security_on_o, watchdog_en_o}, 16'h0004);
    chk(rom_base_o, ROM_HIGH_BASE);
    wr(ADDR_CONFIG, 8'h04);
    repeat (2) @(posedge clk_i);
    chk({14'h0000, pullup_enable_o, security_on_o}, 16'h0001);
    chk(rom_base_o, ROM_HIGH_BASE);
    repeat (70) @(posedge clk_i);
    wr(ADDR_OPTION, 8'h03);
    rd(ADDR_OPTION, d);
    chk(16'(d), 16'h0003);
    $display("t_special done");
  endtask
  task automatic t_watchdog();
    int n;
    boot(1'b1, 1'b1, 8'h1A);
    chk(16'(watchdog_en_o), 16'h0001);
    wr(ADDR_OPTION, 8'h01);
    wait_rst(n);
    rng(n, 56, 84);
    wait_fetch();
    chk(16'(reset_cause_o), 16'(CAUSE_WDT));
    chk(vec_addr_o, VEC_WDT);
    repeat (8) @(posedge clk_i);
    wr(ADDR_WDSVC, WD_ARM_KEY);
    wr(ADDR_WDSVC, WD_CLR_KEY);
    wait_rst(n);
    rng(n, 14, 40);
    $display("t_watchdog done");
  endtask
  initial begin
    t_normal();
    t_special();
    t_watchdog();
    end_sim();
  end
endmodule
